// ---- src/chip_select_defs.svh ----
// constants for the chip select and wait state decoder
// assumes inclusion by the decoder module
// Overview of operation
// - each select serves memory or io space
// - reset leaves every select in memory space
// - select never asserts unless enabled
// - memory match when lower<=addr[23:16]<=upper
// - lowest numbered matching select wins
// - on-chip ram suppresses memory selects
// - memory selects only during memory access
// - memory access drives select, memory_request_strobe, rd/wr
// - equal bounds cover one 64 KB page
// - select 0 resets to full range
// - io selects only during io instruction
// - io match on addr[11:4] equals lower
// - io decode ignores memory page base
// - no io select for addr[7:0] >= 80h
// - io access drives select, io_request_strobe, rd/wr
// - each select has 0..7 wait states
// - wait field ctl[7:5] stretches access
`ifndef CHIP_SELECT_DEFS_SVH
`define CHIP_SELECT_DEFS_SVH
`define CS_NUM          4
`define CS_WAIT_MSB     7
`define CS_WAIT_LSB     5
`define CS_IO_BIT       4
`define CS_EN_BIT       3
`define CS_MEM_HI       23
`define CS_MEM_LO       16
`define CS_IO_HI        11
`define CS_IO_LO        4
`define CS_PERIPH_BIT   7
`define CS0_LBR_RST     8'h00
`define CS0_UBR_RST     8'hFF
`define CS0_CTL_RST     8'hE8
`define LOWER_BOUND_BYTE_RST     8'h00
`define UPPER_BOUND_BYTE_RST     8'h00
`define SELECT_CONTROL_REGISTER_RST     8'h00
`define CS_WAIT_ZERO    3'h0
`endif

// ---- src/chip_select_pkg.sv ----
// types for the chip select and wait state decoder
// uses nothing from chip_select_defs.svh
`default_nettype none
package chip_select_pkg;
  // one access request from the cpu side
  typedef struct packed {
    logic        mem;
    logic        io;
    logic        rd;
    logic        wr;
    logic [23:0] addr;
  } bus_req_t;
  // programming of one select
  typedef struct packed {
    logic [7:0] lower;
    logic [7:0] upper;
    logic [7:0] ctl;
  } cs_cfg_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } cs_state_t;
endpackage
`default_nettype wire

// ---- src/chip_select_wait_decoder.sv ----
// chip select and wait state decoder, four selects
// assumes cpu holds a request until done pulses, and that
// config writes are pulses with one select index
`include "chip_select_defs.svh"
`default_nettype none
module chip_select_wait_decoder #(
  parameter int NUM_CS = `CS_NUM
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rstn,
  input  wire chip_select_pkg::bus_req_t req,
  input  wire logic                      ram_hit,
  input  wire logic                      cfg_we,
  input  wire logic [1:0]                cfg_sel,
  input  wire chip_select_pkg::cs_cfg_t  cfg_wdata,
  output logic [NUM_CS-1:0]              select_out_n_ff,
  output logic                           memory_request_strobe_n_ff,
  output logic                           io_request_strobe_n_ff,
  output logic                           rd_n_ff,
  output logic                           wr_n_ff,
  output logic                           done_ff,
  output chip_select_pkg::cs_cfg_t       cfg_rdata_ff
);
  chip_select_pkg::cs_cfg_t  cfg_ff [NUM_CS];
  chip_select_pkg::cs_state_t state_ff;
  chip_select_pkg::cs_state_t nxt_state;
  logic [2:0]                wait_ff;
  logic [2:0]                nxt_wait;
  logic [NUM_CS-1:0]         hit;
  logic [NUM_CS-1:0]         win;
  logic [NUM_CS-1:0]         nxt_sel_n;
  logic [2:0]                win_wait;
  logic                      active;
  logic [NUM_CS-1:0]         en_vec;
  logic [3:0]                low_run_ff;
  wire  logic                io_periph;
  wire  logic                req_live;

  // peripheral registers own io addresses 80h..ffh
  // periph range blocks
  assign io_periph = req.addr[`CS_PERIPH_BIT];
  assign req_live  = (req.mem | req.io) & (req.rd | req.wr);

  genvar g;
  generate
    for (g = 0; g < NUM_CS; g++) begin : g_cs
      wire logic en  = cfg_ff[g].ctl[`CS_EN_BIT];
      wire logic sio = cfg_ff[g].ctl[`CS_IO_BIT];
      assign en_vec[g] = en;
      wire logic mhit = (req.addr[`CS_MEM_HI:`CS_MEM_LO] >= cfg_ff[g].lower)
                      & (req.addr[`CS_MEM_HI:`CS_MEM_LO] <= cfg_ff[g].upper);
      wire logic ihit = req.addr[`CS_IO_HI:`CS_IO_LO] == cfg_ff[g].lower;
      assign hit[g] = en & ((~sio & req.mem & ~ram_hit & mhit)
                          | (sio & req.io & ~io_periph & ihit));
      if (g == 0) begin : g_first
        assign win[g] = hit[g];
      end else begin : g_rest
        assign win[g] = hit[g] & ~|hit[g-1:0];
      end
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          cfg_ff[g].lower <= (g == 0) ? `CS0_LBR_RST : `LOWER_BOUND_BYTE_RST;
          cfg_ff[g].upper <= (g == 0) ? `CS0_UBR_RST : `UPPER_BOUND_BYTE_RST;
          cfg_ff[g].ctl   <= (g == 0) ? `CS0_CTL_RST : `SELECT_CONTROL_REGISTER_RST;
        end else if (cfg_we && cfg_sel == 2'(g)) begin
          cfg_ff[g] <= cfg_wdata;
        end
      end
    end
  endgenerate

  always_comb begin
    win_wait = `CS_WAIT_ZERO;
    for (int i = 0; i < NUM_CS; i++) begin
      if (win[i]) begin
        win_wait = cfg_ff[i].ctl[`CS_WAIT_MSB:`CS_WAIT_LSB];
      end
    end
  end

  assign active = req_live & |win;

  // idle -> wait (n cycles) -> done pulse -> idle; request must drop
  always_comb begin
    nxt_state = state_ff;
    nxt_wait  = wait_ff;
    nxt_sel_n = select_out_n_ff;
    case (state_ff)
      chip_select_pkg::ST_IDLE: begin
        nxt_sel_n = '1;
        if (active) begin
          nxt_sel_n = ~win;
          nxt_wait  = win_wait;
          nxt_state = (win_wait == `CS_WAIT_ZERO)
                    ? chip_select_pkg::ST_DONE : chip_select_pkg::ST_WAIT;
        end
      end
      chip_select_pkg::ST_WAIT: begin
        nxt_wait = wait_ff - 3'd1;
        if (wait_ff == 3'd1) begin
          nxt_state = chip_select_pkg::ST_DONE;
        end
      end
      chip_select_pkg::ST_DONE: begin
        nxt_sel_n = '1;
        nxt_state = chip_select_pkg::ST_IDLE;
      end
      default: begin
        nxt_sel_n = '1;
        nxt_state = chip_select_pkg::ST_IDLE;
      end
    endcase
  end

  wire logic strobe_on = (nxt_state != chip_select_pkg::ST_IDLE)
                       & (nxt_sel_n != '1);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff                   <= chip_select_pkg::ST_IDLE;
      wait_ff                    <= `CS_WAIT_ZERO;
      select_out_n_ff            <= '1;
      memory_request_strobe_n_ff <= 1'b1;
      io_request_strobe_n_ff     <= 1'b1;
      rd_n_ff                    <= 1'b1;
      wr_n_ff                    <= 1'b1;
      done_ff                    <= 1'b0;
    end else begin
      state_ff                   <= nxt_state;
      wait_ff                    <= nxt_wait;
      select_out_n_ff            <= nxt_sel_n;
      memory_request_strobe_n_ff <= ~(strobe_on & req.mem);
      io_request_strobe_n_ff     <= ~(strobe_on & req.io);
      rd_n_ff                    <= ~(strobe_on & req.rd);
      wr_n_ff                    <= ~(strobe_on & req.wr & ~req.rd);
      done_ff                    <= (nxt_state == chip_select_pkg::ST_DONE);
    end
  end

  // readback of the selected configuration
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata_ff <= '0;
    end else begin
      cfg_rdata_ff <= cfg_ff[cfg_sel];
    end
  end

  // at most one select low at a time
  one_hot_sel_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $countones(~select_out_n_ff) <= 1) else $error("two selects low");
  // select only when enabled; config is not rewritten mid access
  enable_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (select_out_n_ff != '1) |->
      |(~select_out_n_ff & en_vec)) else $error("select while off");
  // helper count of cycles a select has been low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      low_run_ff <= 4'h0;
    end else begin
      low_run_ff <= (select_out_n_ff != '1) ? low_run_ff + 4'h1 : 4'h0;
    end
  end
  wait_bound_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    low_run_ff <= 4'h8) else $error("access stretched too long");
  // ram access raises no memory select
  ram_block_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (req.mem && ram_hit && !req.io) |-> win == '0)
    else $error("select during ram hit");
  // peripheral io range never selects
  periph_block_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (req.io && !req.mem && io_periph) |-> win == '0)
    else $error("io select in periph range");
  // strobe asserts together with select, one cycle after the start
  sequence start_s;
    state_ff == chip_select_pkg::ST_IDLE && active && req.mem && !req.io;
  endsequence
  mem_strobe_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    start_s |=> !memory_request_strobe_n_ff && select_out_n_ff != '1)
    else $error("memory strobe missing");
  sequence io_start_s;
    state_ff == chip_select_pkg::ST_IDLE && active && req.io && !req.mem;
  endsequence
  io_strobe_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    io_start_s |=> !io_request_strobe_n_ff)
    else $error("io strobe missing");
  // zero waits gives done next cycle
  zero_wait_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_ff == chip_select_pkg::ST_IDLE && active && win_wait == 3'd0)
      |=> done_ff) else $error("zero wait late");
  // select held through wait cycles
  hold_wait_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_ff == chip_select_pkg::ST_WAIT) |=> $stable(select_out_n_ff))
    else $error("select dropped in wait");
  // idle with no request keeps selects high
  idle_high_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_ff == chip_select_pkg::ST_IDLE && !active) |=>
      select_out_n_ff == '1) else $error("select low when idle");
endmodule
`default_nettype wire

// ---- test/ext_chips.sv ----
// external chip model: times each select assertion
// assumes registered active low selects from the decoder
`default_nettype none
module ext_chips (
  input  wire logic       sys_clk,
  input  wire logic [3:0] sel_n,
  output logic      [3:0] low_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = '0;
  initial low_cnt = '0;
  always @(posedge sys_clk) begin
    if (!(&sel_n)) low_cnt <= busy ? low_cnt + 4'h1 : 4'h1;
    busy <= !(&sel_n);
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// bench for the chip select decoder: random and corner accesses
// assumes the decoder package and the external chip model
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      sys_clk = '0, rstn = '1, ram_hit = '0;
  logic                      cfg_we = '0, memory_request_strobe_n, io_request_strobe_n, rd_n, wr_n, done;
  logic [1:0]                cfg_sel = '0;
  logic [3:0]                sel_n, low_cnt;
  logic [31:0]               seed = 32'h0001_7bfb, x, y;
  chip_select_pkg::bus_req_t req = '0, r;
  chip_select_pkg::cs_cfg_t  cfg_wdata = '0, rdata, cfg [4];
  int                        errors = 0, n_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  chip_select_wait_decoder dut_u (.sys_clk(sys_clk), .rstn(rstn),
    .req(req), .ram_hit(ram_hit), .cfg_we(cfg_we), .cfg_sel(cfg_sel),
    .cfg_wdata(cfg_wdata), .select_out_n_ff(sel_n),
    .memory_request_strobe_n_ff(memory_request_strobe_n), .io_request_strobe_n_ff(io_request_strobe_n),
    .rd_n_ff(rd_n), .wr_n_ff(wr_n), .done_ff(done), .cfg_rdata_ff(rdata));
  ext_chips chips_u (.sys_clk(sys_clk), .sel_n(sel_n), .low_cnt(low_cnt));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // lowest numbered qualifying select, 4 when none
  function automatic int winner(chip_select_pkg::bus_req_t q, logic rh);
    for (int i = 0; i < 4; i++) begin
      if (cfg[i].ctl[3] && cfg[i].ctl[4] && q.io && !q.addr[7] &&
          q.addr[11:4] == cfg[i].lower) return i;
      if (cfg[i].ctl[3] && !cfg[i].ctl[4] && q.mem && !rh &&
          q.addr[23:16] >= cfg[i].lower && q.addr[23:16] <= cfg[i].upper)
        return i;
    end
    return 4;
  endfunction
  task automatic check(input string nm, input logic [23:0] s, e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cfg_write(input logic [1:0] i, input logic [23:0] v);
    cfg_we = 1'h1;
    cfg_sel = i;
    cfg_wdata = v;
    cfg[i] = v;
    @(negedge sys_clk);
    cfg_we = 1'h0;
    @(negedge sys_clk);
    check("cfg readback", rdata, v);
  endtask
  // driven at a falling edge; request held until done
  task automatic access(input chip_select_pkg::bus_req_t q, input logic rh);
    int w, k;
    logic bad;
    w = winner(q, rh);
    bad = 1'h0;
    req = q;
    ram_hit = rh;
    for (k = 0; k < 12; k++) begin
      @(negedge sys_clk);
      if (done === 1'h1) break;
      if (w == 4 && sel_n !== 4'hf) bad = 1'h1;
    end
    if (w == 4) check("refused", {bad, done}, 0);
    else if (k == 12) begin
      check("done", 0, 1);
      final_report();
    end else begin
      check("select", sel_n, 4'(~(4'h1 << w)));
      check("memory_request_strobe", memory_request_strobe_n, !q.mem);
      check("io_request_strobe", io_request_strobe_n, !q.io);
      check("rd wr", {rd_n, wr_n}, {!q.rd, !q.wr});
    end
    req = '0;
    ram_hit = 1'h0;
    @(negedge sys_clk);
    if (w != 4) check("stretch", low_cnt, cfg[w].ctl[7:5] + 1);
  endtask
  initial begin
    // a real falling edge on rstn, so the async reset branch runs
    #1 rstn = 1'h0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'h1;
    for (int i = 0; i < 4; i++) begin
      cfg[i] = (i == 0) ? 24'h00_ffe8 : '0;
      cfg_sel = 2'(i);
      @(negedge sys_clk);
      check("reset cfg", rdata, cfg[i]);
    end
    // random programming every 25 accesses, bounds hit on purpose
    for (int n = 0; n < 110; n++) begin
      if (n % 25 == 10)
        for (int i = 0; i < 4; i++) begin
          y = rnd();
          cfg_write(2'(i), {y[23:3], 3'h0});
        end
      x = rnd();
      y = rnd();
      r = {x[0], !x[0], x[1], !x[1], y[23:0]};
      if (!x[0]) r.addr[11:4] = cfg[x[3:2]].lower;
      else if (x[4])
        r.addr[23:16] = x[5] ? cfg[x[3:2]].upper : cfg[x[3:2]].lower;
      access(r, x[0] & (x[9:7] == 3'h0));
    end
    final_report();
  end
endmodule
`default_nettype wire
